/* trsp_port.sv */
// remote start, stop and recall port with its test state control
`timescale 1ns/1ps
module trsp_port #(
	parameter int FILTER_CYC    = trsp_pkg::FILTER_CYC,
	parameter int START_MIN_CYC = trsp_pkg::START_MIN_CYC,
	parameter int FLASH_CYC     = trsp_pkg::FLASH_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic                       pready,
	output logic      [31:0]           prdata,
	output logic                       pslverr,
	input  wire logic                  port_enable_n,
	input  wire logic                  port_start_n,
	input  wire logic                  port_stop_n,
	input  wire logic                  recall_strobe,
	input  wire logic                  test_select_0,
	input  wire logic                  test_select_1,
	input  wire logic [7:0]            recall_number,
	input  wire logic                  panel_start_n,
	input  wire logic                  panel_stop_n,
	input  wire logic                  jack_start_n,
	input  wire logic                  jack_stop_n,
	input  wire logic                  aux_supply_overcurrent_n,
	input  wire logic                  dc_function_present,
	input  wire logic                  test_pass,
	input  wire logic                  test_fail,
	output logic                       ready_n,
	output logic                       protection_on,
	output logic                       test_running,
	output logic                       remote_flag,
	output logic                       ocp_flash,
	output logic                       start_pulse,
	output logic                       stop_pulse,
	output logic                       recall_pulse,
	output trsp_pkg::trsp_recall_t     recall
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic digit_ok(input logic [3:0] d);
		digit_ok = (d <= 4'h9);
	endfunction : digit_ok

	function automatic logic [6:0] bcd_to_bin(input logic [3:0] tens, input logic [3:0] units);
		bcd_to_bin = 7'({tens, 3'b000}) + 7'({tens, 1'b0}) + 7'(units);
	endfunction : bcd_to_bin

	// ----------------------------------------------------------------
	// input conditioning
	// ----------------------------------------------------------------
	logic [trsp_pkg::IN_W-1:0] pins_n;
	logic [trsp_pkg::IN_W-1:0] f_n;

	assign pins_n = {aux_supply_overcurrent_n, jack_stop_n, jack_start_n, panel_stop_n, panel_start_n,
	                 recall_number, test_select_1, test_select_0, recall_strobe,
	                 port_stop_n, port_start_n, port_enable_n};

	trsp_in_filter #(
		.FILTER_CYC (FILTER_CYC)
	) u_filter (
		.clk     (clk),
		.reset_n (reset_n),
		.pins_n  (pins_n),
		.clean_n (f_n)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	trsp_pkg::trsp_state_t  state_reg, state_next;
	logic [trsp_pkg::START_CNT_W-1:0] start_cnt_reg, start_cnt_next;
	logic [trsp_pkg::FLASH_CNT_W-1:0] flash_cnt_reg, flash_cnt_next;
	logic                   en_prev_reg, en_prev_next;
	logic                   stb_prev_reg, stb_prev_next;
	logic                   remote_reg, remote_next;
	logic                   ocp_reg, ocp_next;
	logic                   flash_reg, flash_next;
	logic                   start_pulse_reg, start_pulse_next;
	logic                   stop_pulse_reg, stop_pulse_next;
	logic                   recall_pulse_reg, recall_pulse_next;
	trsp_pkg::trsp_recall_t recall_reg, recall_next;
	logic                   fail_latch_reg, fail_latch_next;
	logic                   sw_stop_reg, sw_stop_next;
	logic [31:0]            prdata_reg, prdata_next;
	logic                   pslverr_reg, pslverr_next;

	logic                   port_auth;
	logic                   start_src_n;
	logic                   start_hit;
	logic                   remote_stop;
	logic                   panel_stop;
	logic                   clr_ok;
	logic                   en_change;
	logic                   ocp;
	logic                   prot_clear;
	logic                   flash_tick;
	logic                   stb_rise;
	logic [3:0]             tens;
	logic [3:0]             units;
	trsp_pkg::trsp_target_t tgt;

	// ----------------------------------------------------------------
	// test control
	// ----------------------------------------------------------------
	always_comb begin
		port_auth = !f_n[trsp_pkg::IN_ENABLE];
		if (port_auth) begin
			start_src_n = f_n[trsp_pkg::IN_START];
		end else begin
			// port start is dropped while the enable line sits high
			start_src_n = f_n[trsp_pkg::IN_PANEL_START] & f_n[trsp_pkg::IN_JACK_START];
		end
		remote_stop = !f_n[trsp_pkg::IN_STOP] | !f_n[trsp_pkg::IN_JACK_STOP] | sw_stop_reg;
		panel_stop  = !f_n[trsp_pkg::IN_PANEL_STOP];
		clr_ok      = panel_stop | (remote_stop & !fail_latch_reg);
		en_change   = f_n[trsp_pkg::IN_ENABLE] != en_prev_reg;
		ocp         = !f_n[trsp_pkg::IN_OCP];
		prot_clear  = (state_reg == trsp_pkg::ST_PROT) && clr_ok && !ocp;

		// counter saturates so one long low time yields a single start
		start_cnt_next = start_cnt_reg;
		start_hit      = 1'b0;
		if (start_src_n) begin
			start_cnt_next = '0;
		end else if (start_cnt_reg != trsp_pkg::START_CNT_W'(START_MIN_CYC)) begin
			start_cnt_next = start_cnt_reg + 1'b1;
			start_hit = (start_cnt_reg == trsp_pkg::START_CNT_W'(START_MIN_CYC - 1));
		end

		state_next       = state_reg;
		start_pulse_next = 1'b0;
		stop_pulse_next  = 1'b0;
		unique case (state_reg)
			trsp_pkg::ST_READY: begin
				if (start_hit) begin
					state_next       = trsp_pkg::ST_TEST;
					start_pulse_next = 1'b1;
				end
			end
			trsp_pkg::ST_TEST: begin
				if (remote_stop || panel_stop) begin
					state_next      = trsp_pkg::ST_READY;
					stop_pulse_next = 1'b1;
				end else if (test_fail) begin
					state_next = trsp_pkg::ST_FAIL;
				end else if (test_pass) begin
					state_next = trsp_pkg::ST_READY;
				end
			end
			trsp_pkg::ST_FAIL: begin
				if (clr_ok) begin
					state_next = trsp_pkg::ST_READY;
				end
			end
			trsp_pkg::ST_PROT: begin
				if (prot_clear) begin
					state_next = trsp_pkg::ST_READY;
				end
			end
		endcase
		// protection outranks every other move, including a stop
		if (en_change || ocp) begin
			state_next       = trsp_pkg::ST_PROT;
			stop_pulse_next  = (state_reg == trsp_pkg::ST_TEST);
			start_pulse_next = 1'b0;
		end

		en_prev_next = f_n[trsp_pkg::IN_ENABLE];
		remote_next  = en_change | (remote_reg & !prot_clear);
		ocp_next     = ocp | (ocp_reg & !prot_clear);
	end

	// ----------------------------------------------------------------
	// overcurrent flash divider
	// ----------------------------------------------------------------
	always_comb begin
		flash_tick     = (flash_cnt_reg == trsp_pkg::FLASH_CNT_W'(FLASH_CYC - 1));
		flash_cnt_next = flash_tick ? '0 : flash_cnt_reg + 1'b1;
		flash_next     = 1'b0;
		if (ocp_reg) begin
			flash_next = flash_tick ? !flash_reg : flash_reg;
		end
	end

	// ----------------------------------------------------------------
	// recall capture
	// ----------------------------------------------------------------
	always_comb begin
		stb_prev_next = f_n[trsp_pkg::IN_STROBE];
		stb_rise      = f_n[trsp_pkg::IN_STROBE] && !stb_prev_reg;
		tens  = ~f_n[trsp_pkg::IN_NUM_LO+4 +: 4];
		units = ~f_n[trsp_pkg::IN_NUM_LO +: 4];
		tgt   = trsp_pkg::trsp_target_t'({f_n[trsp_pkg::IN_SEL1], f_n[trsp_pkg::IN_SEL0]});
		recall_next       = recall_reg;
		recall_pulse_next = 1'b0;
		if (stb_rise) begin
			recall_pulse_next  = 1'b1;
			recall_next.target = tgt;
			recall_next.number = bcd_to_bin(tens, units);
			recall_next.valid  = digit_ok(tens) && digit_ok(units)
			                     && !(tgt == trsp_pkg::TGT_DC && !dc_function_present);
		end
	end

	// ----------------------------------------------------------------
	// apb slave, zero wait states, read data staged in the setup cycle
	// ----------------------------------------------------------------
	always_comb begin
		fail_latch_next = fail_latch_reg;
		sw_stop_next    = 1'b0;
		prdata_next     = prdata_reg;
		pslverr_next    = pslverr_reg;
		if (psel && !penable) begin
			prdata_next  = 32'h0000_0000;
			pslverr_next = 1'b0;
			unique case (paddr)
				trsp_pkg::CTRL_OFS: begin
					prdata_next[trsp_pkg::CTRL_FAIL_LATCH_BIT] = fail_latch_reg;
				end
				trsp_pkg::STATUS_OFS: begin
					prdata_next[5:0] = {dc_function_present, ocp_reg, remote_reg, port_auth, state_reg};
				end
				trsp_pkg::RECALL_OFS: begin
					prdata_next[9:0] = recall_reg;
				end
				default: begin
					pslverr_next = 1'b1;
				end
			endcase
		end
		if (psel && penable && pwrite && pstrb[0] && paddr == trsp_pkg::CTRL_OFS) begin
			fail_latch_next = pwdata[trsp_pkg::CTRL_FAIL_LATCH_BIT];
			sw_stop_next    = pwdata[trsp_pkg::CTRL_SW_STOP_BIT];
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg        <= trsp_pkg::ST_READY;
			start_cnt_reg    <= '0;
			flash_cnt_reg    <= '0;
			en_prev_reg      <= 1'b1;
			stb_prev_reg     <= 1'b1;
			remote_reg       <= 1'b0;
			ocp_reg          <= 1'b0;
			flash_reg        <= 1'b0;
			start_pulse_reg  <= 1'b0;
			stop_pulse_reg   <= 1'b0;
			recall_pulse_reg <= 1'b0;
			recall_reg       <= trsp_pkg::RECALL_RST;
			fail_latch_reg   <= trsp_pkg::CTRL_FAIL_LATCH_RST;
			sw_stop_reg      <= 1'b0;
			prdata_reg       <= 32'h0000_0000;
			pslverr_reg      <= 1'b0;
		end else begin
			state_reg        <= state_next;
			start_cnt_reg    <= start_cnt_next;
			flash_cnt_reg    <= flash_cnt_next;
			en_prev_reg      <= en_prev_next;
			stb_prev_reg     <= stb_prev_next;
			remote_reg       <= remote_next;
			ocp_reg          <= ocp_next;
			flash_reg        <= flash_next;
			start_pulse_reg  <= start_pulse_next;
			stop_pulse_reg   <= stop_pulse_next;
			recall_pulse_reg <= recall_pulse_next;
			recall_reg       <= recall_next;
			fail_latch_reg   <= fail_latch_next;
			sw_stop_reg      <= sw_stop_next;
			prdata_reg       <= prdata_next;
			pslverr_reg      <= pslverr_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign ready_n       = (state_reg != trsp_pkg::ST_READY);
	assign protection_on = (state_reg == trsp_pkg::ST_PROT);
	assign test_running  = (state_reg == trsp_pkg::ST_TEST);
	assign remote_flag   = remote_reg;
	assign ocp_flash     = flash_reg;
	assign start_pulse   = start_pulse_reg;
	assign stop_pulse    = stop_pulse_reg;
	assign recall_pulse  = recall_pulse_reg;
	assign recall        = recall_reg;
	assign pready        = 1'b1;
	assign prdata        = prdata_reg;
	assign pslverr       = pslverr_reg & psel & penable;

endmodule : trsp_port

/* trsp_pkg.sv */
// shared constants and types of the remote start and recall port
package trsp_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ        = 100000;
	localparam int START_MIN_MS   = 5;
	localparam int START_MIN_CYC  = START_MIN_MS * CLK_KHZ;
	localparam int FILTER_US      = 200;
	localparam int FILTER_CYC     = (FILTER_US * CLK_KHZ + 999) / 1000;
	localparam int FLASH_HALF_MS  = 250;
	localparam int FLASH_CYC      = FLASH_HALF_MS * CLK_KHZ;
	localparam int FILT_CNT_W     = 20;
	localparam int START_CNT_W    = 20;
	localparam int FLASH_CNT_W    = 25;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] RECALL_OFS = 8'h08;

	localparam int CTRL_FAIL_LATCH_BIT = 0;
	localparam int CTRL_SW_STOP_BIT    = 1;
	localparam logic CTRL_FAIL_LATCH_RST = 1'b0;

	// ----------------------------------------------------------------
	// input vector layout, active low at the pins except test_select_0 and test_select_1
	// ----------------------------------------------------------------
	localparam int IN_W          = 19;
	localparam int IN_ENABLE     = 0;
	localparam int IN_START      = 1;
	localparam int IN_STOP       = 2;
	localparam int IN_STROBE     = 3;
	localparam int IN_SEL0       = 4;
	localparam int IN_SEL1       = 5;
	localparam int IN_NUM_LO     = 6;
	localparam int IN_PANEL_START = 14;
	localparam int IN_PANEL_STOP = 15;
	localparam int IN_JACK_START = 16;
	localparam int IN_JACK_STOP  = 17;
	localparam int IN_OCP        = 18;
	localparam logic [IN_W-1:0] IN_RST = 19'h7ffff;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_READY = 2'b00,
		ST_TEST  = 2'b01,
		ST_FAIL  = 2'b10,
		ST_PROT  = 2'b11
	} trsp_state_t;

	// code equals {test_select_1, test_select_0} as seen on the pins
	typedef enum logic [1:0] {
		TGT_SEQ = 2'b00,
		TGT_IR  = 2'b01,
		TGT_DC  = 2'b10,
		TGT_AC  = 2'b11
	} trsp_target_t;

	typedef struct packed {
		logic         valid;
		trsp_target_t target;
		logic [6:0]   number;
	} trsp_recall_t;

	localparam trsp_recall_t RECALL_RST = 10'h000;

endpackage : trsp_pkg

/* trsp_in_filter.sv */
// synchroniser and stability filter for the active-low port inputs
`timescale 1ns/1ps
module trsp_in_filter #(
	parameter int FILTER_CYC = trsp_pkg::FILTER_CYC
) (
	input  wire logic                       clk,
	input  wire logic                       reset_n,
	input  wire logic [trsp_pkg::IN_W-1:0]  pins_n,
	output logic      [trsp_pkg::IN_W-1:0]  clean_n
);

	localparam int W = trsp_pkg::IN_W;
	localparam int CW = trsp_pkg::FILT_CNT_W;

	logic [W-1:0]  s1_reg;
	logic [W-1:0]  s2_reg;
	logic [W-1:0]  out_reg;
	logic [W-1:0]  out_next;
	logic [CW-1:0] cnt_reg  [W];
	logic [CW-1:0] cnt_next [W];

	// ----------------------------------------------------------------
	// a bit follows its pin only after it held still for the whole window
	// ----------------------------------------------------------------
	always_comb begin
		out_next = out_reg;
		for (int i = 0; i < W; i++) begin
			cnt_next[i] = '0;
			if (s2_reg[i] != out_reg[i]) begin
				if (cnt_reg[i] == CW'(FILTER_CYC - 1)) begin
					out_next[i] = s2_reg[i];
				end else begin
					cnt_next[i] = cnt_reg[i] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// pulled-up pins read as high until something pulls them
			s1_reg  <= trsp_pkg::IN_RST;
			s2_reg  <= trsp_pkg::IN_RST;
			out_reg <= trsp_pkg::IN_RST;
			for (int i = 0; i < W; i++) begin
				cnt_reg[i] <= '0;
			end
		end else begin
			s1_reg  <= pins_n;
			s2_reg  <= s1_reg;
			out_reg <= out_next;
			for (int i = 0; i < W; i++) begin
				cnt_reg[i] <= cnt_next[i];
			end
		end
	end

	assign clean_n = out_reg;

endmodule : trsp_in_filter

/* trsp_port_monitor.sv */
// assertions on the ports of the remote start and recall port
`timescale 1ns/1ps
module trsp_port_monitor #(
	parameter int FILTER_CYC    = 4,
	parameter int START_MIN_CYC = 20,
	parameter int FLASH_CYC     = 8
) (
	input wire logic                   clk,
	input wire logic                   reset_n,
	input wire logic                   port_enable_n,
	input wire logic                   port_stop_n,
	input wire logic                   jack_stop_n,
	input wire logic                   panel_stop_n,
	input wire logic                   recall_strobe,
	input wire logic                   aux_supply_overcurrent_n,
	input wire logic                   dc_function_present,
	input wire logic                   ready_n,
	input wire logic                   protection_on,
	input wire logic                   test_running,
	input wire logic                   remote_flag,
	input wire logic                   start_pulse,
	input wire logic                   stop_pulse,
	input wire logic                   recall_pulse,
	input wire trsp_pkg::trsp_recall_t recall
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire any_stop_n = port_stop_n & jack_stop_n & panel_stop_n;

	// ----
	// state outputs
	// ----
	AST_READY_STATE: assert property (!ready_n |-> !test_running && !protection_on)
		else $error("ready shown outside ready state");
	AST_START_READY: assert property (start_pulse |-> test_running && ready_n && !$past(ready_n))
		else $error("start taken without leaving ready");
	// filter plus sync is well under twelve cycles when FILTER_CYC is 4
	AST_STOP_END: assert property ($fell(any_stop_n) && test_running |-> ##[1:12] !test_running)
		else $error("stop did not end the test");
	AST_STOP_PULSE: assert property (stop_pulse |-> !test_running && $past(test_running))
		else $error("stop pulse without a test ending");
	AST_PROT_ENABLE: assert property ($changed(port_enable_n) |-> ##[1:12] (protection_on && remote_flag))
		else $error("enable change without protection");
	AST_OCP_PROT: assert property ($fell(aux_supply_overcurrent_n) |-> ##[1:12] protection_on)
		else $error("overcurrent without protection");

	// ----
	// recall
	// ----
	AST_RECALL_EDGE: assert property ($rose(recall_strobe) |-> ##[1:12] recall_pulse)
		else $error("strobe rise not captured");
	AST_RECALL_NO_DC: assert property (recall_pulse && recall.target == trsp_pkg::TGT_DC
		&& !dc_function_present |-> !recall.valid)
		else $error("dc recall valid without dc function");
	AST_RECALL_RANGE: assert property (recall_pulse && recall.valid |-> recall.number <= 7'd99)
		else $error("recall number above range");

	COV_START: cover property (start_pulse);
	COV_RECALL: cover property (recall_pulse && recall.valid);
	COV_REMOTE: cover property (protection_on && remote_flag);
endmodule : trsp_port_monitor

bind trsp_port trsp_port_monitor #(.FILTER_CYC(FILTER_CYC), .START_MIN_CYC(START_MIN_CYC), .FLASH_CYC(FLASH_CYC))
	i_trsp_port_monitor (.clk, .reset_n, .port_enable_n, .port_stop_n, .jack_stop_n, .panel_stop_n,
	.recall_strobe, .aux_supply_overcurrent_n, .dc_function_present, .ready_n, .protection_on,
	.test_running, .remote_flag, .start_pulse, .stop_pulse, .recall_pulse, .recall);

/* trsp_ctrl_model.sv */
// external controller driving the port pins
`timescale 1ns/1ps
module trsp_ctrl_model (
	input wire logic clk,
	input wire logic ready_n,
	output logic       port_enable_n,
	output logic       port_start_n,
	output logic       port_stop_n,
	output logic       recall_strobe,
	output logic       test_select_0,
	output logic       test_select_1,
	output logic [7:0] recall_number
);
	// released pins read high through the pull-ups
	initial begin
		{port_enable_n, port_start_n, port_stop_n, recall_strobe} = 4'hf;
		{test_select_1, test_select_0} = 2'b11;
		recall_number = 8'hff;
	end

	task automatic set_enable(input logic v);
		@(posedge clk);
		port_enable_n <= v;
		repeat (12) @(posedge clk);
	endtask : set_enable

	// settle after ready low is a fixed eight cycles, whatever the start width
	task automatic start(input int hold);
		while (ready_n !== 1'b0) @(posedge clk);
		repeat (8) @(posedge clk);
		port_start_n <= 1'b0;
		repeat (hold) @(posedge clk);
		port_start_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : start

	task automatic stop();
		@(posedge clk);
		port_stop_n <= 1'b0;
		repeat (12) @(posedge clk);
		port_stop_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : stop

	// one-cycle spike, short enough for the input filter to drop
	task automatic glitch(input logic [1:0] m);
		{port_start_n, port_stop_n} <= ~m;
		@(posedge clk);
		{port_start_n, port_stop_n} <= 2'b11;
	endtask : glitch

	task automatic recall(input logic [1:0] sel, input logic [7:0] num);
		while (ready_n !== 1'b0) @(posedge clk);
		{test_select_1, test_select_0} <= sel;
		recall_number <= num;
		recall_strobe <= 1'b0;
		repeat (8) @(posedge clk);
		recall_strobe <= 1'b1;
		repeat (12) @(posedge clk);
		{test_select_1, test_select_0} <= 2'b11;
		recall_number <= 8'hff;
		@(posedge clk);
	endtask : recall
endmodule : trsp_ctrl_model

/* tb_trsp_port.sv */
// self-checking bench for the remote start and recall port
`timescale 1ns/1ps
module tb_trsp_port;
	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, e, f;
	logic [7:0]  paddr, recall_number;
	logic [31:0] pwdata, prdata, q, r;
	logic [3:0]  pstrb, t, u;
	logic [1:0]  sel;
	logic [10:0] ev;
	logic        port_enable_n, port_start_n, port_stop_n, recall_strobe, test_select_0, test_select_1;
	logic        panel_start_n, panel_stop_n, jack_start_n, jack_stop_n, aux_supply_overcurrent_n;
	logic        dc_function_present, test_pass, test_fail, ready_n, protection_on, test_running, remote_flag;
	logic        ocp_flash, start_pulse, stop_pulse, recall_pulse;
	trsp_pkg::trsp_recall_t recall;
	logic [10:0] exp_q[$];
	int          n_mismatch, compares, seed, cycles, i, n_stop;
	// masks over {panel_start_n, panel_stop_n, jack_start_n, jack_stop_n}
	localparam logic [3:0] PANEL_START = 4'h8;
	localparam logic [3:0] PANEL_STOP  = 4'h4;
	localparam logic [3:0] JACK_START  = 4'h2;
	localparam logic [3:0] JACK_STOP   = 4'h1;

	trsp_port #(.FILTER_CYC(4), .START_MIN_CYC(20), .FLASH_CYC(8)) i_trsp_port (.clk, .reset_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .port_enable_n, .port_start_n,
		.port_stop_n, .recall_strobe, .test_select_0, .test_select_1, .recall_number, .panel_start_n,
		.panel_stop_n, .jack_start_n, .jack_stop_n, .aux_supply_overcurrent_n, .dc_function_present,
		.test_pass, .test_fail, .ready_n, .protection_on, .test_running, .remote_flag, .ocp_flash,
		.start_pulse, .stop_pulse, .recall_pulse, .recall);
	trsp_ctrl_model i_trsp_ctrl_model (.clk, .ready_n, .port_enable_n, .port_start_n, .port_stop_n,
		.recall_strobe, .test_select_0, .test_select_1, .recall_number);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----
	// helpers
	// ----
	task automatic ck(input string n, input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", n, x, s);
		end
	endtask : ck

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic pin_pulse(input logic [3:0] m, input int n);
		{panel_start_n, panel_stop_n, jack_start_n, jack_stop_n} <= ~m;
		wt(n);
		{panel_start_n, panel_stop_n, jack_start_n, jack_stop_n} <= 4'hf;
		wt(4);
	endtask : pin_pulse

	task end_of_test;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	// ----
	// result watcher
	// ----
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_of_test();
		end
		if (reset_n === 1'b1 && stop_pulse === 1'b1) n_stop++;
		if (reset_n === 1'b1 && (start_pulse === 1'b1 || recall_pulse === 1'b1)) begin
			if (exp_q.size() == 0) ck("unexpected pulse", 1, 0);
			else begin
				ev = exp_q.pop_front();
				if (ev[10]) ck("recall", recall & (ev[9] ? 10'h3ff : 10'h380), ev[9:0] & (ev[9] ? 10'h3ff : 10'h380));
				else ck("start", {test_running, ready_n}, 2'b11);
			end
		end
	end

	initial begin
		seed = 32'h3aeb;
		{reset_n, psel, penable, pwrite, test_pass, test_fail} = '0;
		{paddr, pwdata, pstrb} = {8'h00, 32'h0, 4'hf};
		{panel_start_n, panel_stop_n, jack_start_n, jack_stop_n, aux_supply_overcurrent_n} = 5'h1f;
		dc_function_present = 1'b1;
		wt(12);
		reset_n <= 1'b1;
		wt(2);
		ck("ready", ready_n, 0);
		ck("idle pins", protection_on, 0);
		apb(0, trsp_pkg::CTRL_OFS, 0);
		ck("ctrl reset", q, 0);
		apb(0, 8'h10, 0);
		ck("unmapped", {q[30:0], e}, 1);
		apb(1, trsp_pkg::CTRL_OFS, 1);
		apb(0, trsp_pkg::CTRL_OFS, 0);
		ck("fail latch", q, 1);
		// a write whose low byte lane is off must leave the latch alone
		r = $random(seed);
		pstrb <= r[3:0] & 4'he;
		apb(1, trsp_pkg::CTRL_OFS, 0);
		pstrb <= 4'hf;
		apb(0, trsp_pkg::CTRL_OFS, 0);
		ck("strobe off", q, 1);
		apb(1, trsp_pkg::CTRL_OFS, 0);
		i_trsp_ctrl_model.start(32);
		ck("port start off", ready_n, 0);
		exp_q.push_back(11'h003);
		pin_pulse(PANEL_START, 32);
		pin_pulse(PANEL_STOP, 12);
		ck("panel stop", ready_n, 0);
		i_trsp_ctrl_model.set_enable(1'b0);
		ck("protection", {protection_on, remote_flag}, 2'b11);
		i_trsp_ctrl_model.stop();
		ck("stop clears", {protection_on, ready_n}, 0);
		pin_pulse(PANEL_START, 32);
		pin_pulse(JACK_START, 32);
		ck("front start off", ready_n, 0);
		// spikes on the port lines and stray engine verdicts outside a test
		r = $random(seed);
		{test_pass, test_fail} <= r[1:0];
		i_trsp_ctrl_model.glitch(r[3:2] | 2'b10);
		{test_pass, test_fail} <= 2'b00;
		wt(8);
		ck("short glitch", ready_n, 0);
		i_trsp_ctrl_model.start(10);
		ck("short start", ready_n, 0);
		exp_q.push_back(11'h003);
		i_trsp_ctrl_model.start(32);
		pin_pulse(JACK_STOP, 12);
		ck("jack stop", {test_running, ready_n}, 0);
		exp_q.push_back(11'h003);
		i_trsp_ctrl_model.start(32);
		i_trsp_ctrl_model.stop();
		ck("port stop", {test_running, ready_n}, 0);
		exp_q.push_back(11'h003);
		i_trsp_ctrl_model.start(32);
		test_pass <= 1'b1;
		wt(1);
		test_pass <= 1'b0;
		wt(2);
		ck("pass ends test", {test_running, ready_n}, 0);
		apb(1, trsp_pkg::CTRL_OFS, 1);
		exp_q.push_back(11'h003);
		i_trsp_ctrl_model.start(32);
		test_fail <= 1'b1;
		wt(1);
		test_fail <= 1'b0;
		i_trsp_ctrl_model.stop();
		ck("latched fail", {test_running, ready_n}, 1);
		pin_pulse(PANEL_STOP, 12);
		ck("panel clears", ready_n, 0);
		apb(1, trsp_pkg::CTRL_OFS, 0);
		aux_supply_overcurrent_n <= 1'b0;
		wt(12);
		ck("ocp", protection_on, 1);
		f = ocp_flash;
		wt(8);
		ck("ocp flash", ocp_flash, !f);
		aux_supply_overcurrent_n <= 1'b1;
		wt(12);
		pin_pulse(PANEL_STOP, 12);
		ck("ocp cleared", ready_n, 0);
		for (i = 0; i < 16; i++) begin
			r = $random(seed);
			sel = (i < 4) ? i[1:0] : r[1:0];
			t = (i == 1) ? 4'd9 : r[7:4] % 10;
			u = (i == 1) ? 4'd9 : (i == 3) ? 4'hc : r[11:8] % 10;
			f = (i == 2) ? 1'b0 : r[12];
			dc_function_present <= f;
			exp_q.push_back({1'b1, !(sel == 2'b10 && !f) && u <= 4'd9, sel, 7'(t * 10 + u)});
			i_trsp_ctrl_model.recall(sel, ~{t, u});
		end
		wt(4);
		ck("pending", exp_q.size(), 0);
		ck("stop pulses", n_stop, 3);
		end_of_test();
	end
endmodule : tb_trsp_port
